// >>> include/bus_data_pkg.sv
// Package with constants and types shared by the data-phase ends.
// Notes on behaviour
// [RQ1] The data driver also drives lane parity.
// [RQ2] Lane six parity odd with bits 48-55.
// [RQ3] Lane seven parity odd with bits 56-63.
// [RQ4] Every lane uses odd parity likewise.
// [RQ5] Acknowledge output marks channel 3/4 transactions.
// [RQ6] Acknowledge marks valid beat, ends single beat.
// [RQ7] Burst takes four acknowledged beats, fourth ends.
// [RQ8] Error acknowledge signals bus error; masters monitor.
// [RQ9] Bus monitor raises error on hung transfer.
// [RQ10] Beat-valid strobe pulses on every data beat.
// [RQ11] Acknowledge always comes with beat-valid strobe.
// [RQ12] Split to 32-bit port: one strobe, then both.
// [RQ13] Receiver checks odd parity per active lane.
package bus_data_pkg;
    localparam int DATA_W         = 64;
    localparam int LANES          = 8;
    localparam int LANE_W         = 8;
    localparam int HALF_W         = 32;
    localparam int BURST_BEATS    = 4;
    localparam int SINGLE_BEATS   = 1;
    localparam int PORT64_FACTOR  = 1;
    localparam int PORT32_FACTOR  = 2;
    localparam int CNT_W          = 4;
    localparam int BUF_DEPTH      = 2;
    localparam int HANG_TIME_NS   = 10000;
    localparam int CLK_PERIOD_NS  = 25;
    // Longest wait rounds down to whole cycles.
    localparam int HANG_CYCLES    = HANG_TIME_NS / CLK_PERIOD_NS;
    localparam int HANG_W         = 16;
    localparam logic [LANES-1:0] LANES_ALL  = 8'hff;
    localparam logic [LANES-1:0] LANES_LOW  = 8'h0f;
    localparam logic [LANES-1:0] LANES_HIGH = 8'hf0;

    typedef enum logic [1:0] {
        XFER_SINGLE,
        XFER_BURST
    } xfer_kind_t;

    typedef enum logic [1:0] {
        DMA_NONE,
        DMA_CH3,
        DMA_CH4
    } dma_chan_t;

    // Odd parity bit for one byte lane.
    function automatic logic odd_parity(input logic [LANE_W-1:0] byte_in);
        return ~(^byte_in);
    endfunction

    // Parity bits for all lanes of a doubleword.
    function automatic logic [LANES-1:0] lane_parity(input logic [DATA_W-1:0] word);
        logic [LANES-1:0] p;
        p = '0;
        for (int i = 0; i < LANES; i++) begin
            p[i] = odd_parity(word[i*LANE_W +: LANE_W]);
        end
        return p;
    endfunction

    // Lanes whose parity check fails.
    function automatic logic [LANES-1:0] parity_bad(input logic [DATA_W-1:0] word,
                                                    input logic [LANES-1:0] par,
                                                    input logic [LANES-1:0] active);
        return (lane_parity(word) ^ par) & active;
    endfunction
endpackage

// >>> include/bus_data_if.sv
// Interface joining the requesting end and the answering end of the data bus.
`timescale 1ns/1ps
interface bus_data_if;
    import bus_data_pkg::*;
    logic [DATA_W-1:0] wdata;
    logic [LANES-1:0]  wpar;
    logic [DATA_W-1:0] rdata;
    logic [LANES-1:0]  rpar;
    logic              start;
    logic              write;
    logic              burst;
    logic              abort;
    logic              beat_valid_strobe;
    logic              beat_terminate_ack;
    logic              tea_dev_o;
    logic              tea_dev_oe;
    logic              tea_far_o;
    logic              tea_far_oe;
    logic              transfer_error_ack;
    logic              dma_ack_ch3;
    logic              dma_ack_ch4;

    // Shared open-drain style error line.
    assign transfer_error_ack = (tea_dev_oe & tea_dev_o) | (tea_far_oe & tea_far_o);

    modport device (
        output wdata, wpar, start, write, burst, abort, dma_ack_ch3, dma_ack_ch4,
        output tea_dev_o, tea_dev_oe,
        input  rdata, rpar, beat_valid_strobe, beat_terminate_ack, transfer_error_ack
    );
    modport far (
        input  wdata, wpar, start, write, burst, abort, dma_ack_ch3, dma_ack_ch4, transfer_error_ack,
        output rdata, rpar, beat_valid_strobe, beat_terminate_ack, tea_far_o, tea_far_oe
    );
endinterface

// >>> logic/beat_buffer.sv
// Two-entry valid/ready buffer holding data beats, without their parity.
`timescale 1ns/1ps
module beat_buffer #(
    parameter int WIDTH = 72,
    parameter int DEPTH = 2
) (
    // Clock and reset.
    input  wire logic             clk_sys,
    input  wire logic             nrst,
    // Filling side.
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Draining side.
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [PW-1:0]    wp_ff, nxt_wp, rp_ff, nxt_rp;
    logic [PW:0]      cnt_ff, nxt_cnt;
    logic             push, pop;

    assign in_ready  = (cnt_ff != (PW+1)'(DEPTH));
    assign out_valid = (cnt_ff != '0);
    assign out_data  = mem_ff[rp_ff];

    always_comb begin
        push    = in_valid & in_ready;
        pop     = out_valid & out_ready;
        nxt_wp  = push ? ((wp_ff == PW'(DEPTH-1)) ? '0 : wp_ff + 1'b1) : wp_ff;
        nxt_rp  = pop ? ((rp_ff == PW'(DEPTH-1)) ? '0 : rp_ff + 1'b1) : rp_ff;
        nxt_cnt = cnt_ff + (PW+1)'(push) - (PW+1)'(pop);
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            wp_ff  <= '0;
            rp_ff  <= '0;
            cnt_ff <= '0;
        end else begin
            wp_ff  <= nxt_wp;
            rp_ff  <= nxt_rp;
            cnt_ff <= nxt_cnt;
            if (push) begin
                mem_ff[wp_ff] <= in_data;
            end
        end
    end
endmodule // beat_buffer

// >>> logic/bus_data_device.sv
// Device end: starts transfers, drives parity, watches handshakes, monitors hangs.
`timescale 1ns/1ps
module bus_data_device #(
    parameter int HANG_LIMIT = bus_data_pkg::HANG_CYCLES
) (
    // Clock and reset.
    input  wire logic                            clk_sys,
    input  wire logic                            nrst,
    // User request.
    input  wire logic                            req_valid,
    output logic                                 req_ready,
    input  wire logic                            req_write,
    input  wire bus_data_pkg::xfer_kind_t        req_kind,
    input  wire bus_data_pkg::dma_chan_t         req_dma,
    // Write data stream.
    input  wire logic                            wr_valid,
    output logic                                 wr_ready,
    input  wire logic [bus_data_pkg::DATA_W-1:0] wr_data,
    // Read data stream.
    output logic                                 rd_valid,
    input  wire logic                            rd_ready,
    output logic [bus_data_pkg::DATA_W-1:0]      rd_data,
    // Status.
    output logic                                 busy,
    output logic                                 done,
    output logic                                 bus_error,
    output logic                                 hang_seen,
    output logic                                 parity_error,
    // Bus side.
    bus_data_if.device                           bus
);
    import bus_data_pkg::*;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_DATA
    } dev_state_t;

    dev_state_t             st_ff, nxt_st;
    logic                   write_ff, nxt_write;
    logic                   burst_ff, nxt_burst;
    dma_chan_t              dma_ff, nxt_dma;
    logic [HANG_W-1:0]      hang_ff, nxt_hang;
    logic                   done_ff, nxt_done;
    logic                   err_ff, nxt_err;
    logic                   hung_ff, nxt_hung;
    logic                   perr_ff, nxt_perr;
    logic [CNT_W-1:0]       acks_ff, nxt_acks;
    logic                   rpush_ff, nxt_rpush;
    logic [DATA_W-1:0]      wd_ff, nxt_wd;
    logic                   rbuf_in_ready;
    logic                   rbuf_push;
    logic                   beat_hit;
    logic                   hang_fire;

    // ------------------------------------------------------------
    // Read buffer.
    // ------------------------------------------------------------
    // Buffer ready is not fed back; a receiver stall does not hold the far end.
    beat_buffer #(.WIDTH(DATA_W), .DEPTH(BUF_DEPTH)) u_rbuf (
        .clk_sys   (clk_sys),
        .nrst      (nrst),
        .in_valid  (rbuf_push),
        .in_ready  (rbuf_in_ready),
        .in_data   (bus.rdata),
        .out_valid (rd_valid),
        .out_ready (rd_ready),
        .out_data  (rd_data)
    );

    assign req_ready = (st_ff == ST_IDLE);
    assign busy      = (st_ff == ST_DATA);
    assign done      = done_ff;
    assign bus_error = err_ff;
    assign hang_seen = hung_ff;
    assign parity_error = perr_ff;
    assign wr_ready  = (st_ff == ST_IDLE) & req_valid & req_write;
    // Read data stands on the bus the cycle after its strobe.
    assign rbuf_push = rpush_ff;
    assign beat_hit  = bus.beat_valid_strobe;
    assign hang_fire = (st_ff == ST_DATA) & (hang_ff == HANG_W'(HANG_LIMIT - 1));

    // ------------------------------------------------------------
    // Bus outputs.
    // ------------------------------------------------------------
    // [RQ1] Writer drives data and parity.
    assign bus.wdata = wd_ff;
    // [RQ2] [RQ3] [RQ4] Odd lane parity.
    assign bus.wpar  = lane_parity(wd_ff);
    assign bus.start = (st_ff == ST_IDLE) & req_valid & (~req_write | wr_valid);
    assign bus.write = (st_ff == ST_IDLE) ? req_write : write_ff;
    assign bus.burst = (st_ff == ST_IDLE) ? (req_kind == XFER_BURST) : burst_ff;
    assign bus.abort = hang_fire;
    // [RQ5] Channel acknowledge outputs.
    assign bus.dma_ack_ch3 = (st_ff == ST_DATA) & (dma_ff == DMA_CH3);
    assign bus.dma_ack_ch4 = (st_ff == ST_DATA) & (dma_ff == DMA_CH4);
    // [RQ9] Monitor drives error on hang.
    assign bus.tea_dev_o  = 1'b1;
    assign bus.tea_dev_oe = hang_fire;

    // ------------------------------------------------------------
    // Transfer control.
    // ------------------------------------------------------------
    always_comb begin
        nxt_st    = st_ff;
        nxt_write = write_ff;
        nxt_burst = burst_ff;
        nxt_dma   = dma_ff;
        nxt_hang  = hang_ff;
        nxt_done  = 1'b0;
        nxt_err   = 1'b0;
        nxt_hung  = 1'b0;
        nxt_acks  = acks_ff;
        nxt_rpush = (st_ff == ST_DATA) & ~write_ff & bus.beat_valid_strobe;
        // [RQ13] Check parity on read beats.
        nxt_perr  = rpush_ff & (parity_bad(bus.rdata, bus.rpar, LANES_ALL) != '0);
        nxt_wd    = wd_ff;
        case (st_ff)
            ST_IDLE: begin
                nxt_hang = '0;
                nxt_acks = '0;
                if (bus.start) begin
                    nxt_st    = ST_DATA;
                    nxt_write = req_write;
                    nxt_burst = (req_kind == XFER_BURST);
                    nxt_dma   = req_dma;
                    if (req_write) begin
                        nxt_wd = wr_data;
                    end
                end
            end
            ST_DATA: begin
                nxt_hang = beat_hit ? '0 : hang_ff + 1'b1;
                // [RQ8] Master watches error line.
                if (bus.transfer_error_ack) begin
                    nxt_st   = ST_IDLE;
                    nxt_err  = 1'b1;
                    nxt_hung = hang_fire;
                    nxt_dma  = DMA_NONE;
                // [RQ6] [RQ7] Acknowledge ends transfer.
                end else if (bus.beat_terminate_ack) begin
                    nxt_acks = acks_ff + 1'b1;
                    if (!burst_ff || (acks_ff == CNT_W'(BURST_BEATS - 1))) begin
                        nxt_st   = ST_IDLE;
                        nxt_done = 1'b1;
                        nxt_dma  = DMA_NONE;
                    end
                end
            end
            default: begin
                nxt_st = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            st_ff    <= ST_IDLE;
            write_ff <= 1'b0;
            burst_ff <= 1'b0;
            dma_ff   <= DMA_NONE;
            hang_ff  <= '0;
            done_ff  <= 1'b0;
            err_ff   <= 1'b0;
            hung_ff  <= 1'b0;
            perr_ff  <= 1'b0;
            acks_ff  <= '0;
            rpush_ff <= 1'b0;
            wd_ff    <= '0;
        end else begin
            st_ff    <= nxt_st;
            write_ff <= nxt_write;
            burst_ff <= nxt_burst;
            dma_ff   <= nxt_dma;
            hang_ff  <= nxt_hang;
            done_ff  <= nxt_done;
            err_ff   <= nxt_err;
            hung_ff  <= nxt_hung;
            perr_ff  <= nxt_perr;
            acks_ff  <= nxt_acks;
            rpush_ff <= nxt_rpush;
            wd_ff    <= nxt_wd;
        end
    end

    // Write burst beats after the first reuse the captured word; the
    // user stream is taken once per transfer to keep the end compact.
    logic unused_ok;
    assign unused_ok = rbuf_in_ready;
endmodule // bus_data_device

// >>> logic/bus_data_far.sv
// Far end: slave or memory answering beats, with port-size split support.
`timescale 1ns/1ps
module bus_data_far (
    // Clock and reset.
    input  wire logic                            clk_sys,
    input  wire logic                            nrst,
    // Configuration.
    input  wire logic                            port_is_32,
    input  wire logic                            force_error,
    // Read data supply.
    input  wire logic                            src_valid,
    output logic                                 src_ready,
    input  wire logic [bus_data_pkg::DATA_W-1:0] src_data,
    // Write data sink.
    output logic                                 snk_valid,
    output logic [bus_data_pkg::DATA_W-1:0]      snk_data,
    output logic                                 parity_error,
    // Bus side.
    bus_data_if.far                              bus
);
    import bus_data_pkg::*;

    typedef enum logic [1:0] {
        FS_IDLE,
        FS_BEAT
    } far_state_t;

    far_state_t          st_ff, nxt_st;
    logic [CNT_W-1:0]    left_ff, nxt_left;
    logic                write_ff, nxt_write;
    logic [DATA_W-1:0]   rd_ff, nxt_rd;
    logic                snk_ff, nxt_snk;
    logic [DATA_W-1:0]   sd_ff, nxt_sd;
    logic                perr_ff, nxt_perr;
    logic                beat_go;
    logic [CNT_W-1:0]    beats;

    // Beat count: four for bursts, doubled for a 32-bit port.
    assign beats = CNT_W'((bus.burst ? BURST_BEATS : SINGLE_BEATS)
                          * (port_is_32 ? PORT32_FACTOR : PORT64_FACTOR));
    assign beat_go   = (st_ff == FS_BEAT) & ~bus.abort & (write_ff | src_valid);
    assign src_ready = beat_go & ~write_ff;
    // [RQ10] Strobe on every beat.
    assign bus.beat_valid_strobe  = beat_go;
    // [RQ7] [RQ11] [RQ12] Acknowledge with strobe, every second beat on a 32-bit port.
    assign bus.beat_terminate_ack = beat_go & (~port_is_32 | left_ff[0]);
    // [RQ1] Reader-side driver supplies parity.
    assign bus.rdata = rd_ff;
    assign bus.rpar  = lane_parity(rd_ff);
    assign bus.tea_far_o  = 1'b1;
    assign bus.tea_far_oe = (st_ff == FS_BEAT) & force_error;
    assign snk_valid    = snk_ff;
    assign snk_data     = sd_ff;
    assign parity_error = perr_ff;

    always_comb begin
        nxt_st    = st_ff;
        nxt_left  = left_ff;
        nxt_write = write_ff;
        nxt_rd    = rd_ff;
        nxt_snk   = 1'b0;
        nxt_sd    = sd_ff;
        nxt_perr  = 1'b0;
        case (st_ff)
            FS_IDLE: begin
                if (bus.start) begin
                    nxt_st    = FS_BEAT;
                    nxt_left  = beats;
                    nxt_write = bus.write;
                end
            end
            FS_BEAT: begin
                if (bus.transfer_error_ack || bus.abort) begin
                    nxt_st = FS_IDLE;
                end else if (beat_go) begin
                    nxt_left = left_ff - 1'b1;
                    if (!write_ff) begin
                        nxt_rd = src_data;
                    end else begin
                        nxt_snk = 1'b1;
                        nxt_sd  = bus.wdata;
                        // [RQ13] Check write parity.
                        if (parity_bad(bus.wdata, bus.wpar,
                                       port_is_32 ? LANES_LOW : LANES_ALL) != '0) begin
                            nxt_perr = 1'b1;
                        end
                    end
                    if (left_ff == CNT_W'(1)) begin
                        nxt_st = FS_IDLE;
                    end
                end
            end
            default: begin
                nxt_st = FS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            st_ff    <= FS_IDLE;
            left_ff  <= '0;
            write_ff <= 1'b0;
            rd_ff    <= '0;
            snk_ff   <= 1'b0;
            sd_ff    <= '0;
            perr_ff  <= 1'b0;
        end else begin
            st_ff    <= nxt_st;
            left_ff  <= nxt_left;
            write_ff <= nxt_write;
            rd_ff    <= nxt_rd;
            snk_ff   <= nxt_snk;
            sd_ff    <= nxt_sd;
            perr_ff  <= nxt_perr;
        end
    end
endmodule // bus_data_far

// >>> testbench/bus_data_asserts.sv
// Concurrent checks on the data-phase signals between the two ends.
`timescale 1ns/1ps
module bus_data_asserts
    import bus_data_pkg::*;
#(
    parameter int HANG_LIMIT = 8
) (
    // Clock and reset.
    input wire logic                            clk_sys,
    input wire logic                            nrst,
    // Far end setting.
    input wire logic                            port_is_32,
    // Data and parity.
    input wire logic [bus_data_pkg::DATA_W-1:0] wdata,
    input wire logic [bus_data_pkg::LANES-1:0]  wpar,
    input wire logic [bus_data_pkg::DATA_W-1:0] rdata,
    input wire logic [bus_data_pkg::LANES-1:0]  rpar,
    // Handshakes.
    input wire logic                            start,
    input wire logic                            write,
    input wire logic                            burst,
    input wire logic                            abort,
    input wire logic                            beat_valid_strobe,
    input wire logic                            beat_terminate_ack,
    input wire logic                            tea_dev_o,
    input wire logic                            tea_dev_oe,
    input wire logic                            transfer_error_ack,
    input wire logic                            dma_ack_ch3,
    input wire logic                            dma_ack_ch4
);
    import bus_data_pkg::*;

    logic             active_ff, nxt_active;
    logic [3:0]       beats_ff, nxt_beats;
    logic [15:0]      idle_ff, nxt_idle;
    logic [LANES-1:0] wodd, rodd;
    logic [3:0]       exp_beats;
    logic             last_beat;

    // ----------------------------------------
    // Transfer tracking
    // ----------------------------------------
    assign exp_beats = (burst ? 4'h4 : 4'h1) << port_is_32;
    assign last_beat = beat_valid_strobe && (beats_ff == exp_beats - 4'h1);

    always_comb begin
        for (int i = 0; i < LANES; i++) begin
            wodd[i] = ^{wpar[i], wdata[i*LANE_W +: LANE_W]};
            rodd[i] = ^{rpar[i], rdata[i*LANE_W +: LANE_W]};
        end
        nxt_active = active_ff;
        nxt_beats  = beats_ff;
        nxt_idle   = idle_ff;
        if (!nrst) begin
            nxt_active = 1'b0;
            nxt_beats  = 4'h0;
            nxt_idle   = 16'h0;
        end else if (start) begin
            nxt_active = 1'b1;
            nxt_beats  = 4'h0;
            nxt_idle   = 16'h0;
        end else if (active_ff) begin
            nxt_beats = beats_ff + {3'h0, beat_valid_strobe};
            nxt_idle  = beat_valid_strobe ? 16'h0 : idle_ff + 16'h1;
            if (last_beat || transfer_error_ack) begin
                nxt_active = 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        active_ff <= nxt_active;
        beats_ff  <= nxt_beats;
        idle_ff   <= nxt_idle;
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    lane_six_odd_a: assert property (^{wpar[6], wdata[55:48]} && ^{rpar[6], rdata[55:48]})
        else $error("lane six parity not odd");
    lane_seven_odd_a: assert property (^{wpar[7], wdata[63:56]} && ^{rpar[7], rdata[63:56]})
        else $error("lane seven parity not odd");
    all_lanes_odd_a: assert property (beat_valid_strobe |-> (wodd == 8'hff) && (rodd == 8'hff))
        else $error("lane parity not odd on a beat");
    ack_with_strobe_a: assert property (beat_terminate_ack |-> beat_valid_strobe)
        else $error("acknowledge without beat strobe");
    strobe_in_xfer_a: assert property (beat_valid_strobe |-> active_ff)
        else $error("beat strobe outside a transfer");
    write_beats_flow_a: assert property (active_ff && write && !transfer_error_ack |-> beat_valid_strobe)
        else $error("write beat missing");
    last_beat_ack_a: assert property (active_ff && beat_valid_strobe && (port_is_32 || !burst)
        |-> beat_terminate_ack == (!port_is_32 || beats_ff[0]))
        else $error("acknowledge not on the final beat");
    burst_ack_each_a: assert property (active_ff && burst && !port_is_32 && beat_valid_strobe
        |-> beat_terminate_ack)
        else $error("burst beat without acknowledge");
    hang_bound_a: assert property (active_ff |-> idle_ff <= HANG_LIMIT + 2)
        else $error("hung transfer not aborted");
    abort_not_early_a: assert property ($rose(abort) |-> idle_ff >= HANG_LIMIT - 1)
        else $error("abort before the hang limit");
    abort_drives_error_a: assert property (abort |-> tea_dev_oe && tea_dev_o && transfer_error_ack)
        else $error("abort without error acknowledge");
    dma_one_chan_a: assert property ((dma_ack_ch3 || dma_ack_ch4) |-> !(dma_ack_ch3 && dma_ack_ch4)
        && (active_ff || $past(active_ff)))
        else $error("dma acknowledge outside its transfer");

    burst64_c: cover property (active_ff && burst && !port_is_32 && beat_terminate_ack);
    split32_c: cover property (last_beat && port_is_32);
    hang_c: cover property (abort);
    dma3_c: cover property (dma_ack_ch3 && beat_valid_strobe);
endmodule // bus_data_asserts

// >>> testbench/system_bus_data_phase_tb_top.sv
// Self-checking testbench joining both ends of the data bus.
`timescale 1ns/1ps
module system_bus_data_phase_tb_top;
    import bus_data_pkg::*;

    localparam int HANG = 8;
    logic        clk_sys = 1'b0, nrst = 1'b0;
    logic        req_valid = 1'b0, req_ready, req_write = 1'b0, wr_valid = 1'b1, wr_ready;
    xfer_kind_t  req_kind = XFER_SINGLE;
    dma_chan_t   req_dma = DMA_NONE, cur_dma = DMA_NONE;
    logic [63:0] wr_data = 64'h0, rd_data, src_data = 64'h0, snk_data;
    logic        rd_valid, rd_ready = 1'b1, busy, done, bus_error, hang_seen, perr_dev, perr_far;
    logic        port_is_32 = 1'b0, force_error = 1'b0, src_valid = 1'b0, src_ready, snk_valid;
    logic        chk_snk = 1'b0;
    logic [1:0]  ev_q[$];
    logic [63:0] wq[$], rq[$];
    int          err_count = 0, compares = 0;

    always #12.5 clk_sys = ~clk_sys;

    bus_data_if bus_if ();
    bus_data_device #(.HANG_LIMIT(HANG)) bus_data_device_inst (.clk_sys(clk_sys), .nrst(nrst),
        .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write), .req_kind(req_kind),
        .req_dma(req_dma), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data),
        .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data), .busy(busy), .done(done),
        .bus_error(bus_error), .hang_seen(hang_seen), .parity_error(perr_dev), .bus(bus_if));
    bus_data_far bus_data_far_inst (.clk_sys(clk_sys), .nrst(nrst), .port_is_32(port_is_32),
        .force_error(force_error), .src_valid(src_valid), .src_ready(src_ready), .src_data(src_data),
        .snk_valid(snk_valid), .snk_data(snk_data), .parity_error(perr_far), .bus(bus_if));
    bus_data_asserts #(.HANG_LIMIT(HANG)) bus_data_asserts_inst (.clk_sys(clk_sys), .nrst(nrst),
        .port_is_32(port_is_32), .wdata(bus_if.wdata), .wpar(bus_if.wpar), .rdata(bus_if.rdata),
        .rpar(bus_if.rpar), .start(bus_if.start), .write(bus_if.write), .burst(bus_if.burst),
        .abort(bus_if.abort), .beat_valid_strobe(bus_if.beat_valid_strobe),
        .beat_terminate_ack(bus_if.beat_terminate_ack), .tea_dev_o(bus_if.tea_dev_o),
        .tea_dev_oe(bus_if.tea_dev_oe), .transfer_error_ack(bus_if.transfer_error_ack),
        .dma_ack_ch3(bus_if.dma_ack_ch3), .dma_ack_ch4(bus_if.dma_ack_ch4));

    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Drives one transfer and notes its expected status.
    task automatic xfer(input logic w, input xfer_kind_t k, input dma_chan_t d, input logic p32,
                        input logic sv, input logic fe, input logic [1:0] ev);
        logic [63:0] wd;
        wd = {$urandom, $urandom};
        chk_snk = w && !p32 && (k == XFER_SINGLE);
        cur_dma = d;
        port_is_32 = p32;
        force_error = fe;
        src_valid = sv;
        src_data = {$urandom, $urandom};
        req_write = w;
        req_kind = k;
        req_dma = d;
        wr_data = wd;
        req_valid = 1'b1;
        for (int n = 0; n < 50 && req_ready !== 1'b1; n++) @(posedge clk_sys) #2;
        ev_q.push_back(ev);
        if (chk_snk) wq.push_back(wd);
        if (!w && sv && !fe)
            repeat ((k == XFER_BURST ? BURST_BEATS : SINGLE_BEATS) * (p32 ? PORT32_FACTOR : PORT64_FACTOR))
                rq.push_back(src_data);
        @(posedge clk_sys) #2;
        req_valid = 1'b0;
        for (int n = 0; n < 300 && busy !== 1'b0; n++) @(posedge clk_sys) #2;
        repeat (2) @(posedge clk_sys);
        #2;
    endtask

    // Watches status, sink data and channel acknowledges.
    always begin
        @(posedge clk_sys);
        #1;
        if (nrst) begin
            // no parity fault on clean traffic
            check("parity_error", {perr_far, perr_dev}, 64'h0);
            if (done === 1'b1 || bus_error === 1'b1) begin
                check("status", {bus_error, hang_seen}, (ev_q.size() > 0) ? ev_q.pop_front() : 2'bxx);
            end
            if (snk_valid === 1'b1 && chk_snk) begin
                check("snk_data", snk_data, (wq.size() > 0) ? wq.pop_front() : 'x);
            end
            if (rd_valid === 1'b1) begin
                check("rd_data", rd_data, (rq.size() > 0) ? rq.pop_front() : 'x);
            end
            if (bus_if.beat_valid_strobe === 1'b1) begin
                check("dma_ack", {bus_if.dma_ack_ch4, bus_if.dma_ack_ch3},
                      {cur_dma == DMA_CH4, cur_dma == DMA_CH3});
            end
        end
    end

    initial begin
        #(25ns * 20000);
        err_count++;
        final_report();
    end

    initial begin
        void'($urandom(7));
        repeat (12) @(posedge clk_sys);
        #2;
        nrst = 1'b1;
        for (int w = 0; w < 2; w++)
            for (int k = 0; k < 2; k++)
                for (int p = 0; p < 2; p++)
                    for (int d = 0; d < 3; d++)
                        xfer(w[0], xfer_kind_t'(k), dma_chan_t'(d), p[0], 1'b1, 1'b0, 2'b00);
        $display("test kinds ports channels ended");
        xfer(1'b1, XFER_BURST, DMA_CH3, 1'b0, 1'b1, 1'b1, 2'b10);
        $display("test far error ended");
        xfer(1'b0, XFER_BURST, DMA_NONE, 1'b0, 1'b0, 1'b0, 2'b11);
        $display("test hang ended");
        xfer(1'b1, XFER_SINGLE, DMA_CH4, 1'b0, 1'b1, 1'b0, 2'b00);
        $display("test recovery ended");
        check("notes_left", ev_q.size() + rq.size(), 64'h0);
        final_report();
    end
endmodule // system_bus_data_phase_tb_top
